// ---- rtl/sfc_params.svh ----
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
// ****************************************************************
// Register offsets (byte addresses on APB).
// ****************************************************************
`define SFC_OFS_INSTR 12'h000
`define SFC_OFS_STATUS 12'h004
`define SFC_OFS_MEMREQ 12'h008
`define SFC_OFS_MEMSTAT 12'h00C
`define SFC_OFS_CONFIG 12'h010
`define SFC_OFS_WAITCNT 12'h014
`define SFC_OFS_EVENTS 12'h018
// ****************************************************************
// Status register bit positions.
// ****************************************************************
`define SFC_BIT_C 0
`define SFC_BIT_Z 1
`define SFC_BIT_N 2
`define SFC_BIT_V 3
`define SFC_BIT_S 4
`define SFC_BIT_H 5
`define SFC_BIT_T 6
`define SFC_BIT_I 7
// ****************************************************************
// Memory request and config fields.
// ****************************************************************
`define SFC_MEMREQ_GO 0
`define SFC_MEMREQ_NVM 1
`define SFC_MEMREQ_BASE_LSB 4
`define SFC_MEMSTAT_BUSY 0
`define SFC_MEMSTAT_DONE 1
`define SFC_CONFIG_MASK 32'h0000_0001
// ****************************************************************
// Reset values and timing counts.
// ****************************************************************
`define SFC_STATUS_RST 8'h00
`define SFC_CONFIG_RST 1'b0
`define SFC_NVM_EXTRA 4'h1
`define SFC_INSTR_CYCLES 4'h1
`endif

// ---- rtl/sfc_pkg.sv ----
package sfc_pkg;
  typedef enum logic [4:0] {
    SFC_OP_IDLE = 5'h00,
    SFC_OP_Z_SET = 5'h01,
    SFC_OP_Z_CLR = 5'h02,
    SFC_OP_I_SET = 5'h03,
    SFC_OP_I_CLR = 5'h04,
    SFC_OP_S_SET = 5'h05,
    SFC_OP_S_CLR = 5'h06,
    SFC_OP_V_SET = 5'h07,
    SFC_OP_V_CLR = 5'h08,
    SFC_OP_T_SET = 5'h09,
    SFC_OP_T_CLR = 5'h0A,
    SFC_OP_H_SET = 5'h0B,
    SFC_OP_H_CLR = 5'h0C,
    SFC_OP_BREAK = 5'h0D,
    SFC_OP_SLEEP = 5'h0E,
    SFC_OP_WDOG = 5'h0F
  } sfc_op_t;
  typedef enum logic [1:0] {
    SFC_MEM_IDLE = 2'b00,
    SFC_MEM_BASE = 2'b01,
    SFC_MEM_EXTRA = 2'b11,
    SFC_MEM_DONE = 2'b10
  } sfc_mem_state_t;
endpackage : sfc_pkg

// ---- rtl/sfc_core.sv ----
`timescale 1ns/1ps
`include "sfc_params.svh"
module sfc_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nvm_busy,
  input wire logic bus_contend,
  output logic break_pulse_ff,
  output logic sleep_pulse_ff,
  output logic wdog_pulse_ff,
  output logic [7:0] status_out_ff
);
  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [7:0] status_ff;
  logic cfg_ff;
  logic mem_nvm_ff;
  logic [7:0] wait_cnt_ff;
  logic [3:0] remain_ff;
  logic [7:0] last_waits_ff;
  logic [7:0] ev_cnt_ff;
  sfc_pkg::sfc_mem_state_t mem_state_ff;
  logic acc;
  logic wr;
  logic mapped;
  logic op_go;
  sfc_pkg::sfc_op_t op;
  logic mem_go;
  logic remain_zero;
  logic extra_done;
  logic mem_finish;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `SFC_OFS_INSTR) || (a == `SFC_OFS_STATUS) || (a == `SFC_OFS_MEMREQ) ||
      (a == `SFC_OFS_MEMSTAT) || (a == `SFC_OFS_CONFIG) || (a == `SFC_OFS_WAITCNT) ||
      (a == `SFC_OFS_EVENTS);
  endfunction : is_mapped

  function automatic logic [3:0] base_cycles(input logic [31:0] d);
    base_cycles = (d[`SFC_MEMREQ_BASE_LSB +: 4] == 4'h0) ? `SFC_INSTR_CYCLES : d[`SFC_MEMREQ_BASE_LSB +: 4];
  endfunction : base_cycles

  assign acc = psel && penable && !pready_ff;
  assign wr = acc && pwrite;
  assign mapped = is_mapped(paddr);
  assign op_go = wr && (paddr == `SFC_OFS_INSTR);
  assign op = sfc_pkg::sfc_op_t'(pwdata[4:0]);
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mem_go = wr && (paddr == `SFC_OFS_MEMREQ) && pwdata[`SFC_MEMREQ_GO] &&
    (mem_state_ff == sfc_pkg::SFC_MEM_IDLE || mem_state_ff == sfc_pkg::SFC_MEM_DONE);
  assign remain_zero = (remain_ff == 4'h0);
  assign extra_done = remain_zero && !nvm_busy && !bus_contend;
  assign mem_finish = (mem_state_ff == sfc_pkg::SFC_MEM_BASE && remain_zero && !mem_nvm_ff) ||
    (mem_state_ff == sfc_pkg::SFC_MEM_EXTRA && extra_done);

  // ****************************************************************
  // APB response.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= acc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pslverr_ff <= acc && !mapped;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_ff <= 32'h0000_0000;
    end
    else if (acc && !pwrite)
    begin
      case (paddr)
        `SFC_OFS_STATUS: prdata_ff <= {24'h00_0000, status_ff};
        `SFC_OFS_MEMSTAT: prdata_ff <= {30'h0000_0000, mem_state_ff == sfc_pkg::SFC_MEM_DONE,
          mem_state_ff != sfc_pkg::SFC_MEM_IDLE && mem_state_ff != sfc_pkg::SFC_MEM_DONE};
        `SFC_OFS_CONFIG: prdata_ff <= {31'h0000_0000, cfg_ff};
        `SFC_OFS_WAITCNT: prdata_ff <= {24'h00_0000, last_waits_ff};
        `SFC_OFS_EVENTS: prdata_ff <= {24'h00_0000, ev_cnt_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
    else
    begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Configuration register.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_ff <= `SFC_CONFIG_RST;
    end
    else if (wr && paddr == `SFC_OFS_CONFIG)
    begin
      cfg_ff <= pwdata[0];
    end
  end

  // ****************************************************************
  // Flag instructions.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_ff <= `SFC_STATUS_RST;
    end
    else if (wr && paddr == `SFC_OFS_STATUS && cfg_ff)
    begin
      status_ff <= pwdata[7:0];
    end
    else if (op_go)
    begin
      case (op)
        sfc_pkg::SFC_OP_Z_SET: status_ff[`SFC_BIT_Z] <= 1'b1;
        sfc_pkg::SFC_OP_Z_CLR: status_ff[`SFC_BIT_Z] <= 1'b0;
        sfc_pkg::SFC_OP_I_SET: status_ff[`SFC_BIT_I] <= 1'b1;
        sfc_pkg::SFC_OP_I_CLR: status_ff[`SFC_BIT_I] <= 1'b0;
        sfc_pkg::SFC_OP_S_SET: status_ff[`SFC_BIT_S] <= 1'b1;
        sfc_pkg::SFC_OP_S_CLR: status_ff[`SFC_BIT_S] <= 1'b0;
        sfc_pkg::SFC_OP_V_SET: status_ff[`SFC_BIT_V] <= 1'b1;
        sfc_pkg::SFC_OP_V_CLR: status_ff[`SFC_BIT_V] <= 1'b0;
        sfc_pkg::SFC_OP_T_SET: status_ff[`SFC_BIT_T] <= 1'b1;
        sfc_pkg::SFC_OP_T_CLR: status_ff[`SFC_BIT_T] <= 1'b0;
        sfc_pkg::SFC_OP_H_SET: status_ff[`SFC_BIT_H] <= 1'b1;
        sfc_pkg::SFC_OP_H_CLR: status_ff[`SFC_BIT_H] <= 1'b0;
        default: status_ff <= status_ff;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_out_ff <= `SFC_STATUS_RST;
    end
    else
    begin
      status_out_ff <= status_ff;
    end
  end

  // ****************************************************************
  // Control instruction strobes.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      break_pulse_ff <= 1'b0;
    end
    else
    begin
      break_pulse_ff <= op_go && op == sfc_pkg::SFC_OP_BREAK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sleep_pulse_ff <= 1'b0;
    end
    else
    begin
      sleep_pulse_ff <= op_go && op == sfc_pkg::SFC_OP_SLEEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wdog_pulse_ff <= 1'b0;
    end
    else
    begin
      wdog_pulse_ff <= op_go && op == sfc_pkg::SFC_OP_WDOG;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ev_cnt_ff <= 8'h00;
    end
    else if (op_go)
    begin
      ev_cnt_ff <= ev_cnt_ff + 8'h01;
    end
  end

  // ****************************************************************
  // Data access timing.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_state_ff <= sfc_pkg::SFC_MEM_IDLE;
    end
    else
    begin
      case (mem_state_ff)
        sfc_pkg::SFC_MEM_IDLE, sfc_pkg::SFC_MEM_DONE:
        begin
          if (mem_go)
          begin
            mem_state_ff <= sfc_pkg::SFC_MEM_BASE;
          end
        end
        sfc_pkg::SFC_MEM_BASE:
        begin
          if (remain_zero)
          begin
            mem_state_ff <= mem_nvm_ff ? sfc_pkg::SFC_MEM_EXTRA : sfc_pkg::SFC_MEM_DONE;
          end
        end
        sfc_pkg::SFC_MEM_EXTRA:
        begin
          if (extra_done)
          begin
            mem_state_ff <= sfc_pkg::SFC_MEM_DONE;
          end
        end
        default:
        begin
          mem_state_ff <= sfc_pkg::SFC_MEM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_nvm_ff <= 1'b0;
    end
    else if (mem_go)
    begin
      mem_nvm_ff <= pwdata[`SFC_MEMREQ_NVM];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      remain_ff <= 4'h0;
    end
    else if (mem_go)
    begin
      remain_ff <= base_cycles(pwdata) - 4'h1;
    end
    else if (mem_state_ff == sfc_pkg::SFC_MEM_BASE && remain_zero && mem_nvm_ff)
    begin
      remain_ff <= `SFC_NVM_EXTRA - 4'h1;
    end
    else if (!remain_zero && (mem_state_ff == sfc_pkg::SFC_MEM_BASE || mem_state_ff == sfc_pkg::SFC_MEM_EXTRA))
    begin
      remain_ff <= remain_ff - 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_cnt_ff <= 8'h00;
    end
    else if (mem_go)
    begin
      wait_cnt_ff <= 8'h01;
    end
    else if (mem_state_ff == sfc_pkg::SFC_MEM_BASE && (!remain_zero || mem_nvm_ff))
    begin
      wait_cnt_ff <= wait_cnt_ff + 8'h01;
    end
    else if (mem_state_ff == sfc_pkg::SFC_MEM_EXTRA && !extra_done)
    begin
      wait_cnt_ff <= wait_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_waits_ff <= 8'h00;
    end
    else if (mem_finish)
    begin
      last_waits_ff <= wait_cnt_ff;
    end
  end
endmodule : sfc_core

// ---- dv/sfc_assertions.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Checker on the ports of the core.
// ****************************************************************
module sfc_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic break_pulse_ff,
  input wire logic sleep_pulse_ff,
  input wire logic wdog_pulse_ff,
  input wire logic [7:0] status_out_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_op(int op);
    s_take ##0 (pwrite && paddr == 12'h000 && pwdata[4:0] == op);
  endsequence
  AST_ANSWER: assert property (s_take |=> pready ##1 !pready)
    else $error("answer timing wrong");
  AST_SET_V: assert property (s_op(7) |-> ##[1:2] status_out_ff[3])
    else $error("overflow flag not set");
  AST_CLR_S: assert property (s_op(6) |-> ##[1:2] !status_out_ff[4])
    else $error("signed flag not cleared");
  AST_SET_H: assert property (s_op(11) |-> ##[1:2] status_out_ff[5])
    else $error("half carry not set");
  AST_SET_T: assert property (s_op(9) |-> ##[1:2] status_out_ff[6])
    else $error("transfer bit not set");
  AST_KEEP: assert property (s_op(13) |-> ##2 $stable(status_out_ff))
    else $error("control instruction moved flags");
  AST_BREAK: assert property (s_op(13) |-> ##[1:2] break_pulse_ff ##1 !break_pulse_ff)
    else $error("break pulse wrong");
  AST_SLEEP: assert property (s_op(14) |-> ##[1:2] sleep_pulse_ff ##1 !sleep_pulse_ff)
    else $error("sleep pulse wrong");
  AST_WDOG: assert property (s_op(15) |-> ##[1:2] wdog_pulse_ff ##1 !wdog_pulse_ff)
    else $error("watchdog pulse wrong");
  AST_UNMAPPED: assert property (s_take ##0 (paddr > 12'h018) |=> pslverr)
    else $error("unmapped access not refused");
endmodule : sfc_assertions
bind sfc_core sfc_assertions i_sfc_assertions (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .break_pulse_ff(break_pulse_ff), .sleep_pulse_ff(sleep_pulse_ff), .wdog_pulse_ff(wdog_pulse_ff),
  .status_out_ff(status_out_ff));

// ---- dv/sfc_mem_partner.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Far side: holds the memory path busy on command.
// ****************************************************************
module sfc_mem_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic kick,
  input wire logic [3:0] hold,
  input wire logic contend,
  output logic nvm_busy,
  output logic bus_contend
);
  logic [3:0] left_ff;
  always_ff @(posedge clk)
  begin
    if (rst) left_ff <= 4'h0;
    else if (kick) left_ff <= hold;
    else if (left_ff != 4'h0) left_ff <= left_ff - 4'h1;
  end
  assign nvm_busy = (left_ff != 4'h0) && !contend;
  assign bus_contend = (left_ff != 4'h0) && contend;
endmodule : sfc_mem_partner

// ---- dv/status_flag_and_control_instr_tb_top.sv ----
`timescale 1ns/1ps
`include "sfc_params.svh"
module status_flag_and_control_instr_tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0, contend = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] hold = 4'h0;
  logic pready, pslverr, er, nvm_busy, bus_contend;
  logic [7:0] st_out;
  int miscompares = 0, n_checks = 0;
  logic [4:0] ops [16] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h0E, 5'h00, 5'h02,
    5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C};
  logic [7:0] exp_st [16] = '{8'h02, 8'h82, 8'h92, 8'h9A, 8'hDA, 8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hF8,
    8'h78, 8'h68, 8'h60, 8'h20, 8'h00};
  sfc_core i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_busy(nvm_busy),
    .bus_contend(bus_contend), .break_pulse_ff(), .sleep_pulse_ff(), .wdog_pulse_ff(), .status_out_ff(st_out));
  sfc_mem_partner i_mem (.clk(clk), .rst(rst), .kick(kick), .hold(hold), .contend(contend),
    .nvm_busy(nvm_busy), .bus_contend(bus_contend));
  initial forever #12.5 clk = ~clk;
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `SFC_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, `SFC_OFS_INSTR, {27'h0, ops[i]});
      apb(1'b0, `SFC_OFS_STATUS, 32'h0000_0000);
      chk(rd, {24'h0, exp_st[i]});
      chk({24'h0, st_out}, {24'h0, exp_st[i]});
    end
    $display("test flags done");
    apb(1'b1, `SFC_OFS_CONFIG, 32'h0000_0001);
    apb(1'b1, `SFC_OFS_STATUS, 32'h0000_00A5);
    apb(1'b0, `SFC_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_00A5);
    apb(1'b0, `SFC_OFS_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    $display("test registers done");
    for (int k = 0; k < 4; k++)
    begin
      hold <= (k > 1) ? 4'h8 : 4'h0;
      contend <= (k == 3);
      kick <= 1'b1;
      apb(1'b1, `SFC_OFS_MEMREQ, {24'h0, 4'h2, 2'h0, k > 0, 1'b1});
      kick <= 1'b0;
      rd = 32'h0000_0000;
      for (int n = 0; n < 30 && rd[1] !== 1'b1; n++) apb(1'b0, `SFC_OFS_MEMSTAT, 32'h0000_0000);
      if (rd[1] !== 1'b1)
      begin
        miscompares++;
        give_verdict();
      end
      apb(1'b0, `SFC_OFS_WAITCNT, 32'h0000_0000);
      if (k < 2) chk(rd, 32'h0000_0002 + k);
      else chk({31'h0, rd > 32'h0000_0003}, 32'h0000_0001);
    end
    apb(1'b1, `SFC_OFS_WAITCNT, 32'h0000_0000);
    apb(1'b0, `SFC_OFS_WAITCNT, 32'h0000_0000);
    chk({31'h0, rd > 32'h0000_0003}, 32'h0000_0001);
    $display("test memory done");
    apb(1'b0, `SFC_OFS_EVENTS, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `SFC_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `SFC_OFS_EVENTS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
    give_verdict();
  end
endmodule : status_flag_and_control_instr_tb_top
